//--- hdl/gate_current_config_bank.sv
`timescale 1ns/10ps
module gate_current_config_bank
  import gate_current_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    reg_wr_en_i,
  input  wire logic                    reg_rd_en_i,
  input  wire logic [5:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wr_data_i,
  input  wire logic                    bridge7_low_current_enable_i,
  input  wire logic                    bridge8_low_current_enable_i,
  output logic      [7:0]              reg_rd_data_o,
  output logic                         reg_hit_o,
  output logic      [3:0]              bridge7_source_current_code_o,
  output logic      [3:0]              bridge7_sink_current_code_o,
  output gate_current_pkg::current_table_e bridge7_current_table_o,
  output logic      [3:0]              bridge8_source_current_code_o,
  output logic      [3:0]              bridge8_sink_current_code_o,
  output gate_current_pkg::current_table_e bridge8_current_table_o
);
  import gate_current_pkg::*;

  logic [7:0] bridge7_gate_current_ctrl_reg;
  logic [7:0] bridge7_gate_current_ctrl_next;
  logic [7:0] bridge8_gate_current_ctrl_reg;
  logic [7:0] bridge8_gate_current_ctrl_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       hit_reg;
  logic       hit_next;

  function automatic logic is_bank_addr(input logic [5:0] addr);
    is_bank_addr = (addr == BRIDGE7_GATE_CURRENT_CTRL_ADDR) || (addr == BRIDGE8_GATE_CURRENT_CTRL_ADDR);
  endfunction : is_bank_addr

  always_comb
  begin
    bridge7_gate_current_ctrl_next = bridge7_gate_current_ctrl_reg;
    bridge8_gate_current_ctrl_next = bridge8_gate_current_ctrl_reg;
    if (reg_wr_en_i && (reg_addr_i == BRIDGE7_GATE_CURRENT_CTRL_ADDR))
    begin
      bridge7_gate_current_ctrl_next = reg_wr_data_i;
    end
    if (reg_wr_en_i && (reg_addr_i == BRIDGE8_GATE_CURRENT_CTRL_ADDR))
    begin
      bridge8_gate_current_ctrl_next = reg_wr_data_i;
    end
  end

  // read data is registered; other addresses belong to other banks and read zero
  always_comb
  begin
    rd_data_next = 8'h00;
    hit_next     = 1'b0;
    if (reg_rd_en_i || reg_wr_en_i)
    begin
      hit_next = is_bank_addr(reg_addr_i);
    end
    if (reg_rd_en_i)
    begin
      case (reg_addr_i)
        BRIDGE7_GATE_CURRENT_CTRL_ADDR: rd_data_next = bridge7_gate_current_ctrl_reg;
        BRIDGE8_GATE_CURRENT_CTRL_ADDR: rd_data_next = bridge8_gate_current_ctrl_reg;
        default:                        rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      bridge7_gate_current_ctrl_reg <= GATE_CURRENT_CTRL_RESET;
      bridge8_gate_current_ctrl_reg <= GATE_CURRENT_CTRL_RESET;
      rd_data_reg                   <= 8'h00;
      hit_reg                       <= 1'b0;
    end
    else
    begin
      bridge7_gate_current_ctrl_reg <= bridge7_gate_current_ctrl_next;
      bridge8_gate_current_ctrl_reg <= bridge8_gate_current_ctrl_next;
      rd_data_reg                   <= rd_data_next;
      hit_reg                       <= hit_next;
    end
  end

  assign reg_rd_data_o = rd_data_reg;
  assign reg_hit_o     = hit_reg;

  // index 0 is bridge 7, index 1 is bridge 8
  logic [7:0]     bridge_ctrl   [2];
  logic           bridge_low    [2];
  logic [3:0]     bridge_source [2];
  logic [3:0]     bridge_sink   [2];
  current_table_e bridge_table  [2];

  assign bridge_ctrl[0] = bridge7_gate_current_ctrl_reg;
  assign bridge_ctrl[1] = bridge8_gate_current_ctrl_reg;
  assign bridge_low[0]  = bridge7_low_current_enable_i;
  assign bridge_low[1]  = bridge8_low_current_enable_i;

  // the analog stage maps code and table to current: codes ascend in both tables
  // code outputs lag the register and table outputs lag the enable input by one cycle, so each comes from a flop
  generate
    for (genvar b = 0; b < 2; b++)
    begin : g_bridge
      bridge_current_select u_bridge_current_select
      (
        .sys_clk_i             (sys_clk_i),
        .rst_n_i               (rst_n_i),
        .ctrl_i                (bridge_ctrl[b]),
        .low_current_enable_i  (bridge_low[b]),
        .source_current_code_o (bridge_source[b]),
        .sink_current_code_o   (bridge_sink[b]),
        .current_table_o       (bridge_table[b])
      );
    end
  endgenerate

  assign bridge7_source_current_code_o = bridge_source[0];
  assign bridge7_sink_current_code_o   = bridge_sink[0];
  assign bridge7_current_table_o       = bridge_table[0];
  assign bridge8_source_current_code_o = bridge_source[1];
  assign bridge8_sink_current_code_o   = bridge_sink[1];
  assign bridge8_current_table_o       = bridge_table[1];

endmodule : gate_current_config_bank

//--- hdl/gate_current_pkg.sv
package gate_current_pkg;

  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned CODE_WIDTH = 4;

  localparam logic [5:0] BRIDGE7_GATE_CURRENT_CTRL_ADDR = 6'h15;
  localparam logic [5:0] BRIDGE8_GATE_CURRENT_CTRL_ADDR = 6'h16;

  localparam logic [7:0] GATE_CURRENT_CTRL_RESET = 8'hFF;

  localparam int unsigned SOURCE_CODE_LSB = 4;
  localparam int unsigned SINK_CODE_LSB   = 0;

  localparam logic [3:0] CODE_MIN = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hF;

  typedef enum logic
  {
    TABLE_STANDARD,
    TABLE_LOW_CURRENT
  } current_table_e;

endpackage : gate_current_pkg

//--- hdl/bridge_current_select.sv
`timescale 1ns/10ps
module bridge_current_select
  import gate_current_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           ctrl_i,
  input  wire logic                 low_current_enable_i,
  output logic      [3:0]           source_current_code_o,
  output logic      [3:0]           sink_current_code_o,
  output current_table_e            current_table_o
);

  logic [3:0]     source_reg;
  logic [3:0]     source_next;
  logic [3:0]     sink_reg;
  logic [3:0]     sink_next;
  current_table_e table_reg;
  current_table_e table_next;

  always_comb
  begin
    source_next = ctrl_i[SOURCE_CODE_LSB +: CODE_WIDTH];
    sink_next   = ctrl_i[SINK_CODE_LSB +: CODE_WIDTH];
    // one bit picks the table for both codes of the bridge
    table_next  = low_current_enable_i ? TABLE_LOW_CURRENT : TABLE_STANDARD;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      source_reg <= CODE_MAX;
      sink_reg   <= CODE_MAX;
      table_reg  <= TABLE_STANDARD;
    end
    else
    begin
      source_reg <= source_next;
      sink_reg   <= sink_next;
      table_reg  <= table_next;
    end
  end

  assign source_current_code_o = source_reg;
  assign sink_current_code_o   = sink_reg;
  assign current_table_o       = table_reg;

endmodule : bridge_current_select

//--- dv/gate_current_properties.sv
`timescale 1ns/10ps
module gate_current_properties
  import gate_current_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       reg_wr_en_i,
  input wire logic       reg_rd_en_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wr_data_i,
  input wire logic       bridge7_low_current_enable_i,
  input wire logic       bridge8_low_current_enable_i,
  input wire logic [7:0] reg_rd_data_o,
  input wire logic       reg_hit_o,
  input wire logic [3:0] bridge7_source_current_code_o,
  input wire logic [3:0] bridge7_sink_current_code_o,
  input current_table_e  bridge7_current_table_o,
  input wire logic [3:0] bridge8_source_current_code_o,
  input wire logic [3:0] bridge8_sink_current_code_o,
  input current_table_e  bridge8_current_table_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr7, wr8, acc;
  assign wr7 = reg_wr_en_i && reg_addr_i == BRIDGE7_GATE_CURRENT_CTRL_ADDR;
  assign wr8 = reg_wr_en_i && reg_addr_i == BRIDGE8_GATE_CURRENT_CTRL_ADDR;
  assign acc = (reg_wr_en_i || reg_rd_en_i) && reg_addr_i inside {6'h15, 6'h16};
  a_hit_on_access: assert property (acc |=> reg_hit_o) else $error("hit missing");
  a_no_stray_hit: assert property (!acc |=> !reg_hit_o) else $error("stray hit");
  a_rd_data_idle: assert property (!reg_rd_en_i |=> reg_rd_data_o == 8'h00) else $error("idle data");
  a_src7_follows: assert property (wr7 |=> ##1 bridge7_source_current_code_o == $past(reg_wr_data_i[7:4], 2))
    else $error("bridge 7 source code");
  a_snk7_follows: assert property (wr7 |=> ##1 bridge7_sink_current_code_o == $past(reg_wr_data_i[3:0], 2))
    else $error("bridge 7 sink code");
  a_src8_follows: assert property (wr8 |=> ##1 bridge8_source_current_code_o == $past(reg_wr_data_i[7:4], 2))
    else $error("bridge 8 source code");
  a_snk8_follows: assert property (wr8 |=> ##1 bridge8_sink_current_code_o == $past(reg_wr_data_i[3:0], 2))
    else $error("bridge 8 sink code");
  a_table7_copy: assert property ($past(rst_n_i) |-> bridge7_current_table_o == $past(bridge7_low_current_enable_i))
    else $error("bridge 7 table");
  a_table8_copy: assert property ($past(rst_n_i) |-> bridge8_current_table_o == $past(bridge8_low_current_enable_i))
    else $error("bridge 8 table");
endmodule : gate_current_properties

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
  import gate_current_pkg::*;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] q; logic h;} row_s;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, lo7 = 1'b0, lo8 = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00, rdata;
  logic       hit;
  logic [3:0] s7, k7, s8, k8;
  current_table_e t7, t8;
  int mismatches = 0, comparisons = 0;
  row_s rows [4] = '{'{6'h15, 8'h3C, 8'h3C, 1'b1}, '{6'h16, 8'hA5, 8'hA5, 1'b1},
                     '{6'h14, 8'h5A, 8'h00, 1'b0}, '{6'h17, 8'h5A, 8'h00, 1'b0}};
  always #2.5 clk = ~clk;
  gate_current_config_bank u_gate_current_config_bank (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_wr_en_i(we),
    .reg_rd_en_i(re), .reg_addr_i(addr), .reg_wr_data_i(wdata), .bridge7_low_current_enable_i(lo7),
    .bridge8_low_current_enable_i(lo8), .reg_rd_data_o(rdata), .reg_hit_o(hit),
    .bridge7_source_current_code_o(s7), .bridge7_sink_current_code_o(k7), .bridge7_current_table_o(t7),
    .bridge8_source_current_code_o(s8), .bridge8_sink_current_code_o(k8), .bridge8_current_table_o(t8));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // strobes rise at a falling edge and drop one cycle later
  task automatic access(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {we, re, addr, wdata} = {w, r, a, d};
    @(negedge clk);
    {we, re} = 2'b00;
  endtask : access
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check("codes 7", {s7, k7}, GATE_CURRENT_CTRL_RESET);
    check("codes 8", {s8, k8}, GATE_CURRENT_CTRL_RESET);
    access(1'b0, 1'b1, 6'h16, 8'h00);
    check("reset read", rdata, 8'hFF);
    foreach (rows[i])
    begin
      access(1'b1, 1'b0, rows[i].a, rows[i].d);
      check("write hit", {7'h00, hit}, {7'h00, rows[i].h});
      access(1'b0, 1'b1, rows[i].a, 8'h00);
      check("read data", rdata, rows[i].q);
    end
    check("codes 7", {s7, k7}, 8'h3C);
    check("codes 8", {s8, k8}, 8'hA5);
    // a read that meets a write sees the old contents
    access(1'b1, 1'b1, 6'h15, 8'h00);
    check("read old", rdata, 8'h3C);
    lo7 = 1'b1;
    repeat (2) @(negedge clk);
    check("codes 7", {s7, k7}, 8'h00);
    check("table 7", {7'h00, t7}, {7'h00, TABLE_LOW_CURRENT});
    check("table 8", {7'h00, t8}, {7'h00, TABLE_STANDARD});
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("codes 7", {s7, k7}, 8'hFF);
    check("table 7", {7'h00, t7}, {7'h00, TABLE_STANDARD});
    tally_and_finish();
  end
endmodule : tb
bind gate_current_config_bank gate_current_properties u_gate_current_properties (.*);
